// *** bench/scan_status_record_func_a_test.sv ***
// testbench for the scan status record assembler
module scan_status_record_func_a_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic scan_done_i = 1'b0;
   logic rd = 1'b0;
   ssr_pkg::ssr_func_a_s func_a = '0;
   ssr_pkg::ssr_record_s record;
   ssr_pkg::ssr_record_s snap;
   logic [31:0] scan_cnt;
   logic range_err;
   logic [31:0] cnt = '0;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;

   // 50 MHz clock
   always #10 mclk_i = ~mclk_i;

   ssr_record i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .scan_done_i(scan_done_i),
      .func_a_i(func_a), .record_o(record), .scan_cnt_o(scan_cnt), .sel_range_err_o(range_err));
   ssr_host_model i_host (.mclk_i(mclk_i), .rd_i(rd), .record_i(record), .snap_o(snap));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [63:0] seen, input logic [63:0] want);
      comparisons++;
      if (seen !== want) begin
         fail_count++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask : check

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim

   // n completed scans back to back, all carrying the same status
   task automatic scan(input ssr_pkg::ssr_func_a_s f, input int n);
      @(negedge mclk_i);
      func_a = f;
      scan_done_i = 1'b1;
      repeat (n) @(negedge mclk_i);
      scan_done_i = 1'b0;
      cnt = cnt + 32'(n);
   endtask : scan

   // host read: one cycle request, snapshot taken on that edge
   task automatic read(output ssr_pkg::ssr_record_s r);
      @(negedge mclk_i);
      rd = 1'b1;
      @(negedge mclk_i);
      rd = 1'b0;
      r = snap;
   endtask : read

   // record as the layout says it must look, reserved bits zero
   function automatic ssr_pkg::ssr_record_s want_rec(input ssr_pkg::ssr_func_a_s f,
      input logic [31:0] c);
      want_rec.scan_cnt = c;
      want_rec.byte12 = {f.active, f.func_a_warn_zone_clear, f.func_a_guard_zone_clear,
         f.restart_lock, f.output_on, 3'h0};
      want_rec.byte13 = {f.bank_sel, f.pair_sel1};
      want_rec.byte14 = {f.pair_sel2, f.pair_sel3};
      want_rec.byte15 = {f.func_a_warn_segment1_clear, f.func_a_warn_segment2_clear,
         f.func_a_guard_segment1_clear, f.func_a_guard_segment2_clear,
         f.func_a_predefined_pair1_chosen, f.func_a_predefined_pair2_chosen, 2'h0};
   endfunction : want_rec

   // hang guard: the whole run needs well under a hundred cycles
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles >= 2000) begin
         fail_count++;
         end_sim();
      end
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      ssr_pkg::ssr_func_a_s f;
      ssr_pkg::ssr_record_s r;
      repeat (20) @(negedge mclk_i);
      reset_n_i = 1'b1;
      read(r);
      check(r, 64'h0);
      check({63'h0, range_err}, 64'h0);
      $display("test power-up done");
      // every selection value 1..10, flags walking through their combinations
      for (int i = 1; i <= 10; i++) begin
         f = {1'b1, i[0], i[1], i[2], i[3], i[3:0], 4'(11 - i), i[3:0], 4'(11 - i),
            i[0], i[1], ~i[0], ~i[1], i[2], i[3]};
         scan(f, 1);
         check(record, want_rec(f, cnt));
         check(record, want_rec(f, cnt));
         check({32'h0, scan_cnt}, {32'h0, cnt});
         check({63'h0, range_err}, 64'h0);
      end
      read(r);
      check(r, want_rec(f, cnt));
      $display("test selection sweep done");
      // status changes without a completed scan must not show or count
      @(negedge mclk_i);
      func_a = ~f;
      repeat (3) @(negedge mclk_i);
      check(record, want_rec(f, cnt));
      // back-to-back scans each count
      scan(f, 4);
      check({32'h0, scan_cnt}, {32'h0, cnt});
      check(record, want_rec(f, cnt));
      $display("test hold and back-to-back done");
      // active with selection 0 is passed through and flagged
      f = '0;
      f.active = 1'b1;
      scan(f, 1);
      check(record, want_rec(f, cnt));
      check({63'h0, range_err}, 64'h1);
      f.active = 1'b0;
      scan(f, 1);
      check(record, want_rec(f, cnt));
      check({63'h0, range_err}, 64'h0);
      $display("test out-of-range done");
      // power cycle in mid-run restarts the counter and clears status
      @(negedge mclk_i);
      reset_n_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      check(record, 64'h0);
      reset_n_i = 1'b1;
      cnt = '0;
      f = {27{1'b1}};
      scan(f, 1);
      check(record, want_rec(f, 32'h1));
      $display("test restart done");
      end_sim();
   end
endmodule : scan_status_record_func_a_test

// *** bench/ssr_host_model.sv ***
// host side model: reads a snapshot of the status record on request
module ssr_host_model (
   // clock
   input wire logic mclk_i,
   // read request and the record the device presents
   input wire logic rd_i,
   input wire ssr_pkg::ssr_record_s record_i,
   // copy as the host holds it
   output ssr_pkg::ssr_record_s snap_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------
   // capture
   // ----------------------------------------
   // the host only reads, so it keeps a copy and never drives the device
   always_ff @(posedge mclk_i) begin
      if (rd_i) begin
         snap_o <= record_i;
      end
   end
endmodule : ssr_host_model

// *** hdl/ssr_pkg.sv ***
// package for the scan status record assembler, bytes 8 to 15
package ssr_pkg;

   // ------------------------------------------------------------
   // record layout
   // ------------------------------------------------------------
   localparam int unsigned SCAN_CNT_W = 32;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned REC_BYTES = 8;
   localparam int unsigned REC_FIRST_BYTE = 8;
   localparam logic [SCAN_CNT_W-1:0] SCAN_CNT_RST = 32'h0000_0000;
   localparam logic [SEL_W-1:0] SEL_MIN = 4'h1;
   localparam logic [SEL_W-1:0] SEL_MAX = 4'hA;
   localparam logic [SEL_W-1:0] SEL_RST = 4'h0;

   // bit positions inside byte 12
   localparam int unsigned B12_ACTIVE = 7;
   localparam int unsigned B12_WARN_CLEAR = 6;
   localparam int unsigned B12_GUARD_CLEAR = 5;
   localparam int unsigned B12_RESTART_LOCK = 4;
   localparam int unsigned B12_OUTPUT_ON = 3;
   // bit positions inside byte 15
   localparam int unsigned B15_WARN_SEG1 = 7;
   localparam int unsigned B15_WARN_SEG2 = 6;
   localparam int unsigned B15_GUARD_SEG1 = 5;
   localparam int unsigned B15_GUARD_SEG2 = 4;
   localparam int unsigned B15_PAIR1 = 3;
   localparam int unsigned B15_PAIR2 = 2;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   // one scan result of protective function a
   typedef struct packed {
      logic active;
      logic func_a_warn_zone_clear;
      logic func_a_guard_zone_clear;
      logic restart_lock;
      logic output_on;
      logic [SEL_W-1:0] bank_sel;
      logic [SEL_W-1:0] pair_sel1;
      logic [SEL_W-1:0] pair_sel2;
      logic [SEL_W-1:0] pair_sel3;
      logic func_a_warn_segment1_clear;
      logic func_a_warn_segment2_clear;
      logic func_a_guard_segment1_clear;
      logic func_a_guard_segment2_clear;
      logic func_a_predefined_pair1_chosen;
      logic func_a_predefined_pair2_chosen;
   } ssr_func_a_s;

   // record bytes 8 to 15, byte 8 is the counter's low byte
   typedef struct packed {
      logic [7:0] byte15;
      logic [7:0] byte14;
      logic [7:0] byte13;
      logic [7:0] byte12;
      logic [SCAN_CNT_W-1:0] scan_cnt;
   } ssr_record_s;

endpackage : ssr_pkg

// *** hdl/ssr_record.sv ***
// scan status record assembler: scan counter and protective function a status
// ----------------------------------------------------------------------------
// Summary of operation
// - 32-bit scan counter counts completed scans
// - counter cleared only by power-up reset
// - byte 12 bit 7 function active
// - byte 12 bit 6 warning zone free
// - byte 12 bit 5 guard zone free
// - byte 12 bit 3 mirrors switching output
// - byte 13 bank and first pair
// - byte 14 high nibble second pair
// - byte 14 low nibble third pair
// - byte 15 bits 7,6 warning segments
// - byte 15 bits 5,4 guard segments
// - byte 15 bits 3,2 predefined pairs
// ----------------------------------------------------------------------------
module ssr_record #(
   parameter int unsigned CNT_W = ssr_pkg::SCAN_CNT_W
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_n_i,
   // scan result from the evaluation logic
   input wire logic scan_done_i,
   input wire ssr_pkg::ssr_func_a_s func_a_i,
   // assembled record
   output ssr_pkg::ssr_record_s record_o,
   output logic [ssr_pkg::SCAN_CNT_W-1:0] scan_cnt_o,
   output logic sel_range_err_o
);

   // ------------------------------------------------------------
   // elaboration check
   // ------------------------------------------------------------
   // the record field is fixed at 32 bits; a narrower counter would misreport
   if (CNT_W != ssr_pkg::SCAN_CNT_W) begin : g_bad_width
      $error("ssr_record: counter width must be 32");
   end
   // the counter must fill whole record bytes, low byte first
   if (ssr_pkg::SCAN_CNT_W % 8 != 0) begin : g_bad_bytes
      $error("ssr_record: counter width is not whole bytes");
   end
   // the selection fields must be able to hold the highest number reported
   if (ssr_pkg::SEL_MAX >= (1 << ssr_pkg::SEL_W)) begin : g_bad_sel
      $error("ssr_record: selection field too narrow");
   end
   // the record carrier must span exactly the eight bytes it stands for
   if ($bits(ssr_pkg::ssr_record_s) != ssr_pkg::REC_BYTES * 8) begin : g_bad_rec
      $error("ssr_record: record carrier has the wrong size");
   end
   // five flags, four selection numbers and six segment or pair flags
   if ($bits(ssr_pkg::ssr_func_a_s) != 5 + 4 * ssr_pkg::SEL_W + 6) begin : g_bad_stat
      $error("ssr_record: status carrier has the wrong size");
   end
   // flag positions must stay clear of the reserved low bits
   if (ssr_pkg::B12_OUTPUT_ON < 3 || ssr_pkg::B15_PAIR2 < 2) begin : g_bad_pos
      $error("ssr_record: flag overlaps a reserved bit");
   end

   // captured status, counter and range flag
   ssr_pkg::ssr_func_a_s status_q;
   logic [ssr_pkg::SCAN_CNT_W-1:0] scan_cnt_q;
   logic [ssr_pkg::SCAN_CNT_W-1:0] scan_cnt_d;
   logic sel_err_q;
   logic sel_err_d;

   // ------------------------------------------------------------
   // scan counter
   // ------------------------------------------------------------
   // plain add drops the carry, so all ones rolls to zero
   assign scan_cnt_d = scan_cnt_q + 32'h0000_0001;

   // only power-up reset clears it; no software clear exists on purpose
   // a host that wants a scan rate must difference two reads, since the
   // count never restarts on its own short of a wrap
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         scan_cnt_q <= ssr_pkg::SCAN_CNT_RST;
      end else if (scan_done_i) begin
         scan_cnt_q <= scan_cnt_d;
      end
   end

   // ------------------------------------------------------------
   // function a status capture
   // ------------------------------------------------------------
   // latched once per completed scan so the host sees a consistent snapshot
   // the price is one cycle of latency behind the evaluation logic
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         status_q <= '0;
      end else if (scan_done_i) begin
         status_q <= func_a_i;
      end
   end

   // a selection outside 1..10 is still reported as given, but flagged while the function is active
   function automatic logic sel_bad(input logic [ssr_pkg::SEL_W-1:0] v);
      sel_bad = (v < ssr_pkg::SEL_MIN) || (v > ssr_pkg::SEL_MAX);
   endfunction : sel_bad

   // range flag only meaningful while the function is active
   always_comb begin
      sel_err_d = func_a_i.active &&
                  (sel_bad(func_a_i.bank_sel) || sel_bad(func_a_i.pair_sel1) ||
                   sel_bad(func_a_i.pair_sel2) || sel_bad(func_a_i.pair_sel3));
   end

   // range flag follows the same snapshot timing as the record
   // so a host never sees a flag that belongs to a different scan
   always_ff @(posedge mclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sel_err_q <= 1'b0;
      end else if (scan_done_i) begin
         sel_err_q <= sel_err_d;
      end
   end

   // ------------------------------------------------------------
   // record packing
   // ------------------------------------------------------------
   // one process builds the whole record so every byte has a single driver;
   // reserved bits are zeroed first and then left untouched
   always_comb begin
      record_o = '0;
      // bytes 8 to 11: counter, low byte first
      record_o.scan_cnt = scan_cnt_q;
      // byte 12: function flags
      record_o.byte12[ssr_pkg::B12_ACTIVE] = status_q.active;
      record_o.byte12[ssr_pkg::B12_WARN_CLEAR] = status_q.func_a_warn_zone_clear;
      record_o.byte12[ssr_pkg::B12_GUARD_CLEAR] = status_q.func_a_guard_zone_clear;
      record_o.byte12[ssr_pkg::B12_RESTART_LOCK] = status_q.restart_lock;
      record_o.byte12[ssr_pkg::B12_OUTPUT_ON] = status_q.output_on;
      // byte 13: bank in the high nibble, first pair in the low nibble
      record_o.byte13 = {status_q.bank_sel, status_q.pair_sel1};
      // byte 14: second and third pair
      record_o.byte14[7:4] = status_q.pair_sel2;
      record_o.byte14[3:0] = status_q.pair_sel3;
      // byte 15: segment flags and predefined pairs
      record_o.byte15[ssr_pkg::B15_WARN_SEG1] = status_q.func_a_warn_segment1_clear;
      record_o.byte15[ssr_pkg::B15_WARN_SEG2] = status_q.func_a_warn_segment2_clear;
      record_o.byte15[ssr_pkg::B15_GUARD_SEG1] = status_q.func_a_guard_segment1_clear;
      record_o.byte15[ssr_pkg::B15_GUARD_SEG2] = status_q.func_a_guard_segment2_clear;
      record_o.byte15[ssr_pkg::B15_PAIR1] = status_q.func_a_predefined_pair1_chosen;
      record_o.byte15[ssr_pkg::B15_PAIR2] = status_q.func_a_predefined_pair2_chosen;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // straight from the flops, no logic between
   assign scan_cnt_o = scan_cnt_q;
   assign sel_range_err_o = sel_err_q;

   // ------------------------------------------------------------
   // counter assertions
   // ------------------------------------------------------------
   // each completed scan moves the count by exactly one
   a_cnt_step: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> scan_cnt_o == $past(scan_cnt_o) + 32'h0000_0001)
      else $error("scan counter did not advance by one");

   // no scan, no movement: only power-up may clear the count
   a_cnt_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !scan_done_i |=> $stable(scan_cnt_o))
      else $error("scan counter changed without a scan");

   // all ones must roll to zero rather than stick
   // out of reach of a short run; kept for formal tools
   a_cnt_wrap: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (scan_done_i && scan_cnt_o == 32'hFFFF_FFFF) |=> scan_cnt_o == 32'h0000_0000)
      else $error("scan counter did not wrap");

   // the separate counter port must never disagree with the record
   a_cnt_mirror: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_cnt_o == record_o.scan_cnt)
      else $error("counter port and record disagree");

   // ------------------------------------------------------------
   // status assertions
   // ------------------------------------------------------------
   // byte 12 flags follow the scan that was just captured
   a_active_bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte12[7] == $past(func_a_i.active))
      else $error("active bit wrong");

   a_zone_bits: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte12[6:5] ==
         $past({func_a_i.func_a_warn_zone_clear, func_a_i.func_a_guard_zone_clear}))
      else $error("zone bits wrong");

   a_guard_bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte12[5] == $past(func_a_i.func_a_guard_zone_clear))
      else $error("guard zone bit wrong");

   // restart interlock bit rides along with the other byte 12 flags
   a_restart_bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte12[4] == $past(func_a_i.restart_lock))
      else $error("restart interlock bit wrong");

   a_output_bit: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte12[3] == $past(func_a_i.output_on))
      else $error("switching output bit wrong");

   // selection nibbles are passed through unchanged, even out of range
   a_byte13_sel: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte13 == $past({func_a_i.bank_sel, func_a_i.pair_sel1}))
      else $error("byte 13 selection wrong");

   // second and third pair share byte 14, high nibble first
   a_pair2_sel: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte14[7:4] == $past(func_a_i.pair_sel2))
      else $error("second pair wrong");

   a_pair3_sel: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte14[3:0] == $past(func_a_i.pair_sel3))
      else $error("third pair wrong");

   // segment and predefined pair flags in byte 15
   a_warn_segs: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte15[7:6] == $past({func_a_i.func_a_warn_segment1_clear,
         func_a_i.func_a_warn_segment2_clear}))
      else $error("warning segment bits wrong");

   a_guard_segs: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte15[5:4] == $past({func_a_i.func_a_guard_segment1_clear,
         func_a_i.func_a_guard_segment2_clear}))
      else $error("guard segment bits wrong");

   a_pair_chosen: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i |=> record_o.byte15[3:2] == $past({func_a_i.func_a_predefined_pair1_chosen,
         func_a_i.func_a_predefined_pair2_chosen}))
      else $error("predefined pair bits wrong");

   // a status change between scans must not leak into the record
   a_record_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !scan_done_i |=> $stable({record_o.byte15, record_o.byte14, record_o.byte13,
         record_o.byte12}))
      else $error("record changed without a scan");

   // range flag: never set while the function is inactive
   a_err_idle: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (scan_done_i && !func_a_i.active) |=> !sel_range_err_o)
      else $error("range flag set for inactive function");

   a_err_zero: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (scan_done_i && func_a_i.active && func_a_i.bank_sel == 4'h0) |=> sel_range_err_o)
      else $error("range flag missed a zero bank");

   a_err_high: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (scan_done_i && func_a_i.active && func_a_i.pair_sel3 > 4'hA) |=> sel_range_err_o)
      else $error("range flag missed a high pair");

   a_err_inrange: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      (scan_done_i && func_a_i.bank_sel inside {[ssr_pkg::SEL_MIN:ssr_pkg::SEL_MAX]}
         && func_a_i.pair_sel1 inside {[ssr_pkg::SEL_MIN:ssr_pkg::SEL_MAX]}
         && func_a_i.pair_sel2 inside {[ssr_pkg::SEL_MIN:ssr_pkg::SEL_MAX]}
         && func_a_i.pair_sel3 inside {[ssr_pkg::SEL_MIN:ssr_pkg::SEL_MAX]})
         |=> !sel_range_err_o)
      else $error("range flag set for valid numbers");

   a_err_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      !scan_done_i |=> $stable(sel_range_err_o))
      else $error("range flag changed without a scan");

   // ------------------------------------------------------------
   // reset and reserved assertions
   // ------------------------------------------------------------
   // first edge after release: everything still at its power-up value
   a_status_reset: assert property (@(posedge mclk_i)
      $rose(reset_n_i) |-> (record_o.byte12 == 8'h00 && record_o.byte15 == 8'h00
         && scan_cnt_o == 32'h0000_0000))
      else $error("record not zero after reset");

   // selection numbers and the range flag also start at zero
   a_sel_reset: assert property (@(posedge mclk_i)
      $rose(reset_n_i) |-> (record_o.byte13 == 8'h00 && record_o.byte14 == 8'h00
         && !sel_range_err_o))
      else $error("selections not zero after reset");

   // two edges into a held reset the record must read all zeros
   a_reset_zero: assert property (@(posedge mclk_i)
      (!reset_n_i ##1 !reset_n_i) |-> (record_o == '0 && !sel_range_err_o))
      else $error("record not zero during reset");

   // reserved positions never carry anything
   a_reserved_low: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
      record_o.byte12[2:0] == 3'h0 && record_o.byte15[1:0] == 2'h0)
      else $error("reserved bits not zero");

   // ------------------------------------------------------------
   // cover properties
   // ------------------------------------------------------------
   // main scenarios the tests are expected to reach, except the counter wrap, which is left for formal tools
   c_scan_done: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i ##1 scan_done_i);
   c_cnt_wrap: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i && scan_cnt_o == 32'hFFFF_FFFF);
   c_zone_violate: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      record_o.byte12[7] && !record_o.byte12[5]);
   c_range_err: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      sel_range_err_o);
   c_sel_max: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
      scan_done_i && func_a_i.bank_sel == ssr_pkg::SEL_MAX);

endmodule : ssr_record
